//--- src/nibble_core_pkg.sv
// constants shared by the nibble execution block and its testbench
// assumes a 32-bit classic wishbone register bus with byte addresses
package nibble_core_pkg;

  // data path widths
  localparam int unsigned NIBBLE_W   = 4;       // accumulator and ram word width
  localparam int unsigned RAM_DEPTH  = 16;      // nibbles reachable by the data pointer
  localparam int unsigned ADR_W      = 8;       // decoded low address bits

  // register byte addresses
  localparam logic [7:0] INSTR_ADDR  = 8'h00;   // write: issue one instruction
  localparam logic [7:0] ACC_ADDR    = 8'h04;   // accumulator
  localparam logic [7:0] CARRY_ADDR  = 8'h08;   // carry flag in bit 0
  localparam logic [7:0] DPTR_ADDR   = 8'h0c;   // data pointer
  localparam logic [7:0] STATUS_ADDR = 8'h10;   // read-only core state
  localparam logic [7:0] WAKE_ADDR   = 8'h14;   // write: leave power-down
  localparam logic [7:0] RAM_BASE    = 8'h40;   // ram window, one nibble per word
  localparam logic [7:0] RAM_MASK    = 8'hc3;   // bits that must match for a ram hit

  // instruction word layout
  localparam int unsigned OPC_LSB    = 0;       // opcode field low bit
  localparam int unsigned IMM_LSB    = 4;       // immediate field low bit

  // status word bit positions
  localparam int unsigned ST_SKIP    = 0;       // next instruction will be skipped
  localparam int unsigned ST_ARMED   = 1;       // power-down instructions armed
  localparam int unsigned ST_MODE    = 2;       // two-bit mode field
  localparam int unsigned ST_WDT     = 4;       // watchdog stop enabled
  localparam int unsigned ST_VDROP   = 5;       // voltage detector kept in power-down
  localparam int unsigned ST_HV      = 6;       // high-voltage variant present

  // reset values
  localparam logic [3:0] ACC_RST     = 4'h0;
  localparam logic [3:0] DPTR_RST    = 4'h0;
  localparam logic [3:0] RAM_RST     = 4'h0;

  // instruction codes carried in the instruction word
  typedef enum logic [3:0] {
    OP_NOP                     = 4'h0,
    OP_ADD_IMM                 = 4'h1,
    OP_ADD_MEMORY              = 4'h2,
    OP_ADD_MEMORY_CARRY        = 4'h3,
    OP_AND_MEMORY              = 4'h4,
    OP_CLOCK_RUN_SLEEP         = 4'h5,
    OP_RAM_BACKUP_SLEEP        = 4'h6,
    OP_SLEEP_ARM               = 4'h7,
    OP_WATCHDOG_STOP_ENABLE    = 4'h8,
    OP_VOLTAGE_DROP_KEEP       = 4'h9
  } opcode_e;

  // core operating modes
  typedef enum logic [1:0] {
    MODE_RUN        = 2'b00,
    MODE_CLOCK_RUN  = 2'b01,
    MODE_RAM_BACKUP = 2'b10
  } mode_e;

endpackage : nibble_core_pkg

//--- src/nibble_alu_if.sv
// signals between the execution block and its nibble arithmetic unit
// assumes both ends share one clock; the unit is purely combinational
`timescale 1ns/1ps
interface nibble_alu_if;
  logic [3:0] acc;        // accumulator operand
  logic [3:0] operand;    // immediate or pointed ram nibble
  logic       carry_in;   // carry added into bit 0
  logic       do_and;     // bitwise and instead of add
  logic [3:0] result;     // value for the accumulator
  logic       carry_out;  // carry out of bit 3

  modport core (output acc, operand, carry_in, do_and, input result, carry_out);
  modport alu  (input acc, operand, carry_in, do_and, output result, carry_out);
endinterface : nibble_alu_if

//--- src/nibble_alu.sv
// nibble adder and and-gate for the accumulator instructions
// assumes operands arrive settled from the execution block each cycle
`timescale 1ns/1ps
module nibble_alu (
  nibble_alu_if.alu bus
);
  logic [4:0] sum;  // five-bit sum keeps the carry out of bit 3

  // sum taken modulo sixteen, overflow is bit 4
  assign sum           = {1'b0, bus.acc} + {1'b0, bus.operand} + {4'h0, bus.carry_in};
  assign bus.result    = bus.do_and ? (bus.acc & bus.operand) : sum[3:0];
  assign bus.carry_out = bus.do_and ? 1'b0 : sum[4];
endmodule : nibble_alu

//--- src/nibble_exec.sv
// accumulator instruction execution and power-down control of a 4-bit core
// assumes a classic wishbone master on clk_i and a synchronous reset
`timescale 1ns/1ps

// Behaviour
// - add-immediate adds nibble constant into accumulator
// - add-immediate skips next when no overflow
// - add-immediate keeps carry flag
// - add-memory adds pointed ram nibble to accumulator
// - add-memory keeps carry, never skips
// - add-memory-carry sums all three, loads carry
// - and-memory masks accumulator, keeps carry, no skip
// - clock-run sleep stops core, clock running
// - ram-backup sleep stops core, ram retained
// - power-down acts only after arming instruction
// - watchdog stop enable set only by instruction
// - voltage-drop keep only on high-voltage variant
module nibble_exec #(
  parameter bit HIGH_VOLTAGE_VARIANT = 1'b1   // enables the voltage-drop keep instruction
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             core_stopped_o,
  output logic             ram_backup_o,
  output logic             watchdog_stop_enable_o,
  output logic             voltage_drop_keep_o
);

  // architectural state
  logic [3:0]                 acc;           // accumulator
  logic                       carry_flag;    // carry flag
  logic [3:0]                 data_pointer;  // ram nibble address
  logic                       skip;          // next instruction becomes a nop
  logic                       armed;         // power-down instructions valid
  logic                       wdt_stop_en;   // watchdog may be stopped
  logic                       vdrop_keep;    // detector stays on in power-down
  nibble_core_pkg::mode_e     mode;          // run or one of the power-down modes
  logic [3:0]                 ram [nibble_core_pkg::RAM_DEPTH]; // data ram
  logic                       ack;           // wishbone acknowledge
  logic [31:0]                rd_data;       // registered read data

  // bus decode
  logic [7:0]                 adr;           // decoded address bits
  logic                       req;           // cycle and strobe together
  logic                       wr_hit;        // write taking effect this edge
  logic                       hit_instr;     // instruction register selected
  logic                       hit_acc;       // accumulator selected
  logic                       hit_carry;     // carry register selected
  logic                       hit_dptr;      // data pointer selected
  logic                       hit_status;    // status register selected
  logic                       hit_wake;      // wake register selected
  logic                       hit_ram;       // ram window selected
  logic [3:0]                 ram_idx;       // ram word under the bus address

  // instruction decode
  nibble_core_pkg::opcode_e   opc;           // opcode from the written word
  logic [3:0]                 imm;           // immediate constant field
  logic                       running;       // core executes instructions
  logic                       issue;         // instruction written while running
  logic                       exec;          // issued and not skipped
  logic                       is_add_imm;    // add immediate executing
  logic                       is_add_mem;    // add memory executing
  logic                       is_add_memc;   // add memory with carry executing
  logic                       is_and_mem;    // and memory executing
  logic                       is_arith;      // any accumulator instruction
  logic                       is_clk_sleep;  // clock-run sleep executing
  logic                       is_ram_sleep;  // ram-backup sleep executing
  logic [3:0]                 pointed_ram_nibble; // ram word at the data pointer

  // next values
  logic [3:0]                 next_acc;
  logic                       next_carry;
  logic [3:0]                 next_dptr;
  logic                       next_skip;
  logic                       next_armed;
  nibble_core_pkg::mode_e     next_mode;
  logic [31:0]                next_rd_data;
  logic [31:0]                status_word;

  nibble_alu_if alu_bus ();

  // arithmetic unit shared by all accumulator instructions
  nibble_alu u_alu (
    .bus (alu_bus)
  );

  // ---- wishbone decode ----
  assign adr        = adr_i[7:0];
  assign req        = cyc_i & stb_i;
  // writes land on the edge where the master samples ack high
  assign wr_hit     = req & we_i & ack & sel_i[0];
  assign hit_instr  = adr == nibble_core_pkg::INSTR_ADDR;
  assign hit_acc    = adr == nibble_core_pkg::ACC_ADDR;
  assign hit_carry  = adr == nibble_core_pkg::CARRY_ADDR;
  assign hit_dptr   = adr == nibble_core_pkg::DPTR_ADDR;
  assign hit_status = adr == nibble_core_pkg::STATUS_ADDR;
  assign hit_wake   = adr == nibble_core_pkg::WAKE_ADDR;
  assign hit_ram    = (adr & nibble_core_pkg::RAM_MASK) == nibble_core_pkg::RAM_BASE;
  assign ram_idx    = adr[5:2];

  // ---- instruction decode ----
  assign opc     = nibble_core_pkg::opcode_e'(dat_i[nibble_core_pkg::OPC_LSB +: 4]);
  assign imm     = dat_i[nibble_core_pkg::IMM_LSB +: 4];
  // a stopped core ignores instruction writes
  assign running = mode == nibble_core_pkg::MODE_RUN;
  assign issue   = wr_hit & hit_instr & running;
  // a skipped instruction is fetched but does nothing
  assign exec    = issue & ~skip;

  assign is_add_imm   = exec & (opc == nibble_core_pkg::OP_ADD_IMM);
  assign is_add_mem   = exec & (opc == nibble_core_pkg::OP_ADD_MEMORY);
  assign is_add_memc  = exec & (opc == nibble_core_pkg::OP_ADD_MEMORY_CARRY);
  assign is_and_mem   = exec & (opc == nibble_core_pkg::OP_AND_MEMORY);
  assign is_arith     = is_add_imm | is_add_mem | is_add_memc | is_and_mem;
  assign is_clk_sleep = exec & (opc == nibble_core_pkg::OP_CLOCK_RUN_SLEEP);
  assign is_ram_sleep = exec & (opc == nibble_core_pkg::OP_RAM_BACKUP_SLEEP);

  assign pointed_ram_nibble = ram[data_pointer];

  // ---- arithmetic operands ----
  assign alu_bus.acc      = acc;
  // immediate for add-immediate, pointed ram nibble otherwise
  assign alu_bus.operand  = is_add_imm ? imm : pointed_ram_nibble;
  assign alu_bus.carry_in = is_add_memc & carry_flag;
  assign alu_bus.do_and   = is_and_mem;

  // accumulator: instruction result wins over a direct bus write
  assign next_acc = is_arith                    ? alu_bus.result
                  : (wr_hit & hit_acc & ~issue) ? dat_i[3:0]
                  :                               acc;

  // only add-memory-with-carry and a carry register write touch the carry flag
  assign next_carry = is_add_memc                 ? alu_bus.carry_out
                    : (wr_hit & hit_carry)        ? dat_i[0]
                    :                               carry_flag;

  assign next_dptr = (wr_hit & hit_dptr) ? dat_i[3:0] : data_pointer;

  // add-immediate without overflow skips; any issued word consumes a skip
  assign next_skip = is_add_imm ? ~alu_bus.carry_out
                   : issue      ? 1'b0
                   :              skip;

  // arming holds until a power-down instruction uses it
  assign next_armed = (exec & (opc == nibble_core_pkg::OP_SLEEP_ARM)) ? 1'b1
                    : ((is_clk_sleep | is_ram_sleep) & armed)         ? 1'b0
                    :                                                   armed;

  // mode selection: armed power-down enters, wake write leaves
  always_comb begin
    next_mode = mode;
    case (mode)
      nibble_core_pkg::MODE_RUN: begin
        if (is_clk_sleep & armed) begin
          next_mode = nibble_core_pkg::MODE_CLOCK_RUN;
        end else if (is_ram_sleep & armed) begin
          next_mode = nibble_core_pkg::MODE_RAM_BACKUP;
        end
      end
      nibble_core_pkg::MODE_CLOCK_RUN,
      nibble_core_pkg::MODE_RAM_BACKUP: begin
        if (wr_hit & hit_wake) begin
          next_mode = nibble_core_pkg::MODE_RUN;
        end
      end
      default: begin
        next_mode = nibble_core_pkg::MODE_RUN;
      end
    endcase
  end

  // status word seen by software
  always_comb begin
    status_word = 32'h0;
    status_word[nibble_core_pkg::ST_SKIP]       = skip;
    status_word[nibble_core_pkg::ST_ARMED]      = armed;
    status_word[nibble_core_pkg::ST_MODE +: 2]  = mode;
    status_word[nibble_core_pkg::ST_WDT]        = wdt_stop_en;
    status_word[nibble_core_pkg::ST_VDROP]      = vdrop_keep;
    status_word[nibble_core_pkg::ST_HV]         = HIGH_VOLTAGE_VARIANT;
  end

  // read mux; unmapped addresses read zero
  assign next_rd_data = hit_acc    ? {28'h0, acc}
                      : hit_carry  ? {31'h0, carry_flag}
                      : hit_dptr   ? {28'h0, data_pointer}
                      : hit_status ? status_word
                      : hit_ram    ? {28'h0, ram[ram_idx]}
                      :              32'h0;

  // ---- bus handshake: ack one cycle after the request, for one cycle ----
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack     <= 1'b0;
      rd_data <= 32'h0;
    end else begin
      ack     <= req & ~ack;
      rd_data <= next_rd_data;
    end
  end

  // ---- core registers ----
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc          <= nibble_core_pkg::ACC_RST;
      carry_flag   <= 1'b0;
      data_pointer <= nibble_core_pkg::DPTR_RST;
      skip         <= 1'b0;
      armed        <= 1'b0;
      mode         <= nibble_core_pkg::MODE_RUN;
    end else begin
      acc          <= next_acc;
      carry_flag   <= next_carry;
      data_pointer <= next_dptr;
      skip         <= next_skip;
      armed        <= next_armed;
      mode         <= next_mode;
    end
  end

  // ---- enables that only an instruction can set, only reset clears ----
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_stop_en <= 1'b0;
      vdrop_keep  <= 1'b0;
    end else begin
      if (exec & (opc == nibble_core_pkg::OP_WATCHDOG_STOP_ENABLE)) begin
        wdt_stop_en <= 1'b1;
      end
      // the low-voltage variant treats this instruction as a nop
      if (exec & (opc == nibble_core_pkg::OP_VOLTAGE_DROP_KEEP) & HIGH_VOLTAGE_VARIANT) begin
        vdrop_keep <= 1'b1;
      end
    end
  end

  // ---- data ram: kept in every mode, written from the bus ----
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < nibble_core_pkg::RAM_DEPTH; i++) begin
        ram[i] <= nibble_core_pkg::RAM_RST;
      end
    end else if (wr_hit & hit_ram) begin
      ram[ram_idx] <= dat_i[3:0];
    end
  end

  // ---- outputs ----
  assign dat_o                  = rd_data;
  assign ack_o                  = ack;
  assign core_stopped_o         = mode != nibble_core_pkg::MODE_RUN;
  assign ram_backup_o           = mode == nibble_core_pkg::MODE_RAM_BACKUP;
  assign watchdog_stop_enable_o = wdt_stop_en;
  assign voltage_drop_keep_o    = vdrop_keep;

  // ---- checks ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // add-immediate result is the modulo-sixteen sum
  property p_add_imm_sum;
    is_add_imm |=> acc == 4'($past(acc) + $past(imm));
  endproperty
  a_add_imm_sum: assert property (p_add_imm_sum) else $error("add-immediate sum wrong");

  // skip follows the absence of overflow
  property p_add_imm_skip;
    is_add_imm |=> skip == (({1'b0, $past(acc)} + {1'b0, $past(imm)}) < 5'h10);
  endproperty
  a_add_imm_skip: assert property (p_add_imm_skip) else $error("add-immediate skip wrong");

  // add-immediate leaves carry alone
  property p_add_imm_carry;
    is_add_imm |=> $stable(carry_flag);
  endproperty
  a_add_imm_carry: assert property (p_add_imm_carry) else $error("add-immediate changed carry");

  // add-memory result uses the pointed nibble
  property p_add_mem_sum;
    is_add_mem |=> acc == 4'($past(acc) + $past(pointed_ram_nibble));
  endproperty
  a_add_mem_sum: assert property (p_add_mem_sum) else $error("add-memory sum wrong");

  // add-memory neither touches carry nor skips
  property p_add_mem_flags;
    is_add_mem |=> $stable(carry_flag) && !skip;
  endproperty
  a_add_mem_flags: assert property (p_add_mem_flags) else $error("add-memory flags wrong");

  // carry and accumulator together hold the five-bit sum
  property p_add_memc;
    is_add_memc |=> {carry_flag, acc} ==
      5'({1'b0, $past(acc)} + {1'b0, $past(pointed_ram_nibble)} + {4'h0, $past(carry_flag)});
  endproperty
  a_add_memc: assert property (p_add_memc) else $error("add-memory-carry wrong");

  // and-memory masks, keeps carry, no skip
  property p_and_mem;
    is_and_mem |=> acc == ($past(acc) & $past(pointed_ram_nibble)) && $stable(carry_flag) && !skip;
  endproperty
  a_and_mem: assert property (p_and_mem) else $error("and-memory wrong");

  // armed clock-run sleep stops the core for two cycles at least
  property p_clk_sleep;
    is_clk_sleep && armed |=> core_stopped_o && !ram_backup_o ##1 core_stopped_o;
  endproperty
  a_clk_sleep: assert property (p_clk_sleep) else $error("clock-run sleep not entered");

  // armed ram-backup sleep enters the backup mode
  property p_ram_sleep;
    is_ram_sleep && armed |=> ram_backup_o && core_stopped_o && !armed;
  endproperty
  a_ram_sleep: assert property (p_ram_sleep) else $error("ram-backup sleep not entered");

  // unarmed power-down leaves the core running
  property p_unarmed;
    (is_clk_sleep || is_ram_sleep) && !armed |=> !core_stopped_o;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed power-down took effect");

  // watchdog enable rises only on its instruction
  property p_wdt;
    $rose(wdt_stop_en) |-> $past(exec && opc == nibble_core_pkg::OP_WATCHDOG_STOP_ENABLE);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog stop enable rose alone");

  // detector keep needs its instruction and the variant
  property p_vdrop;
    $rose(vdrop_keep) |-> HIGH_VOLTAGE_VARIANT &&
      $past(exec && opc == nibble_core_pkg::OP_VOLTAGE_DROP_KEEP);
  endproperty
  a_vdrop: assert property (p_vdrop) else $error("voltage drop keep rose alone");

  // a skipped word changes neither accumulator nor carry
  property p_skip_nop;
    issue && skip |=> $stable(acc) && $stable(carry_flag) && !skip;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skipped instruction executed");

endmodule : nibble_exec

//--- tb/testbench.sv
// self-checking bench for the nibble execution block over classic wishbone
// assumes the block acks every access one cycle after it is taken
`timescale 1ns/1ps
module testbench;
  // short local names for the register map
  localparam logic [7:0] R_INS = nibble_core_pkg::INSTR_ADDR;
  localparam logic [7:0] R_ACC = nibble_core_pkg::ACC_ADDR;
  localparam logic [7:0] R_CY  = nibble_core_pkg::CARRY_ADDR;
  localparam logic [7:0] R_DP  = nibble_core_pkg::DPTR_ADDR;
  localparam logic [7:0] R_ST  = nibble_core_pkg::STATUS_ADDR;
  localparam logic [7:0] R_WK  = nibble_core_pkg::WAKE_ADDR;
  localparam logic [7:0] R_RAM = nibble_core_pkg::RAM_BASE;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i;   // clock, reset, bus strobes
  logic [31:0] adr_i, dat_i, dat_o, rd;            // bus address and data
  logic [3:0]  sel_i, a, m, imm, dp, op;           // byte enables and operands
  logic        ack_o, core_stopped_o, ram_backup_o, watchdog_stop_enable_o;
  logic        voltage_drop_keep_o, c;             // outputs and carry operand
  logic [5:0]  e;                                  // expected skip, carry, acc
  int          n_fail, total_checks;               // mismatch and check counts

  nibble_exec #(.HIGH_VOLTAGE_VARIANT(1'b1)) u_nibble_exec (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .core_stopped_o(core_stopped_o), .ram_backup_o(ram_backup_o),
    .watchdog_stop_enable_o(watchdog_stop_enable_o),
    .voltage_drop_keep_o(voltage_drop_keep_o));

  // free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // compare a bus word
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: word got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  // compare a single flag
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: flag got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // one classic cycle; request held until ack is sampled, read data taken on that edge, return at the falling edge
  task automatic wb_cycle(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= {24'h0, ad}; dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    // a missing ack ends the run through the same verdict as the watchdog
    if (n >= 20) begin
      n_fail++;
      $display("Error at %0t: no ack", $time);
      test_done();
    end
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(negedge clk_i);
  endtask : wb_cycle

  // issue one instruction word
  task automatic issue(input logic [3:0] code, input logic [3:0] k);
    wb_cycle(1'b1, R_INS, {24'h0, k, code});
  endtask : issue

  // expected {skip, carry, acc} after one accumulator instruction
  function automatic logic [5:0] expect_op(input logic [3:0] o, input logic [3:0] x,
                                          input logic [3:0] y, input logic [3:0] k,
                                          input logic ci);
    logic [4:0] s;
    s = {1'b0, x} + {1'b0, (o == 4'h1) ? k : y} + {4'h0, (o == 4'h3) & ci};
    case (o)
      4'h1:    return {~s[4], ci, s[3:0]};
      4'h2:    return {1'b0, ci, s[3:0]};
      4'h3:    return {1'b0, s[4], s[3:0]};
      default: return {1'b0, ci, x & y};
    endcase
  endfunction : expect_op

  // hang guard
  initial begin
    #200000;
    n_fail++;
    $display("Error at %0t: timeout", $time);
    test_done();
  end

  // main sequence
  initial begin
    n_fail = 0; total_checks = 0; rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0;
    we_i = 1'b0; adr_i = 32'h0; dat_i = 32'h0; sel_i = 4'hf;
    void'($urandom(32'hc666));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_cycle(1'b0, R_ST, 32'h0);
    chk_word(rd, 32'h0000_0040);
    // random accumulator work, the first three are boundary cases
    for (int i = 0; i < 40; i++) begin
      op = 4'($urandom_range(4, 1)); a = 4'($urandom); m = 4'($urandom);
      imm = 4'($urandom); dp = 4'($urandom); c = 1'($urandom);
      if (i == 0) begin op = 4'h1; a = 4'hf; imm = 4'h1; end
      if (i == 1) begin op = 4'h1; a = 4'h0; imm = 4'hf; end
      if (i == 2) begin op = 4'h3; a = 4'hf; m = 4'hf; c = 1'b1; end
      wb_cycle(1'b1, R_DP, {28'h0, dp});
      wb_cycle(1'b1, R_RAM + {2'b00, dp, 2'b00}, {28'h0, m});
      wb_cycle(1'b1, R_ACC, {28'h0, a});
      wb_cycle(1'b1, R_CY, {31'h0, c});
      issue(op, imm);
      e = expect_op(op, a, m, imm, c);
      wb_cycle(1'b0, R_ACC, 32'h0);
      chk_word(rd, {28'h0, e[3:0]});
      wb_cycle(1'b0, R_CY, 32'h0);
      chk_word(rd, {31'h0, e[4]});
      wb_cycle(1'b0, R_ST, 32'h0);
      chk_bit(rd[nibble_core_pkg::ST_SKIP], e[5]);
      if (e[5]) begin
        issue(4'h1, 4'h1);
        wb_cycle(1'b0, R_ACC, 32'h0);
        chk_word(rd, {28'h0, e[3:0]});
        // the skipped word consumes the pending skip
        wb_cycle(1'b0, R_ST, 32'h0);
        chk_bit(rd[nibble_core_pkg::ST_SKIP], 1'b0);
      end
    end
    // unarmed sleep is ignored, armed sleep stops the core
    issue(4'h5, 4'h0);
    chk_bit(core_stopped_o, 1'b0);
    issue(4'h7, 4'h0);
    issue(4'h5, 4'h0);
    chk_bit(core_stopped_o, 1'b1);
    chk_bit(ram_backup_o, 1'b0);
    wb_cycle(1'b1, R_ACC, 32'h3);
    issue(4'h1, 4'h1);
    wb_cycle(1'b0, R_ACC, 32'h0);
    chk_word(rd, 32'h3);
    wb_cycle(1'b1, R_WK, 32'h1);
    chk_bit(core_stopped_o, 1'b0);
    // ram back-up keeps ram contents
    wb_cycle(1'b1, R_RAM + 8'h14, 32'ha);
    issue(4'h7, 4'h0);
    issue(4'h6, 4'h0);
    chk_bit(ram_backup_o, 1'b1);
    chk_bit(core_stopped_o, 1'b1);
    wb_cycle(1'b0, R_RAM + 8'h14, 32'h0);
    chk_word(rd, 32'ha);
    wb_cycle(1'b1, R_WK, 32'h1);
    issue(4'h6, 4'h0);
    chk_bit(ram_backup_o, 1'b0);
    // sticky enables
    chk_bit(watchdog_stop_enable_o, 1'b0);
    issue(4'h8, 4'h0);
    chk_bit(watchdog_stop_enable_o, 1'b1);
    chk_bit(voltage_drop_keep_o, 1'b0);
    issue(4'h9, 4'h0);
    chk_bit(voltage_drop_keep_o, 1'b1);
    wb_cycle(1'b0, 8'hfc, 32'h0);
    chk_word(rd, 32'h0);
    test_done();
  end
endmodule : testbench
